// >>> shared/conv_ctrl_pkg.sv
package conv_ctrl_pkg;
  // times in whole nanoseconds so the cycle counts divide exactly
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int RESET_HOLD_NS = 9200;
  localparam int SENSE_CONV_NS = 4200;
  localparam int RESET_HOLD_CYC = RESET_HOLD_NS / CLOCK_PERIOD_NS;
  localparam int SENSE_CONV_CYC = SENSE_CONV_NS / CLOCK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 4;
  localparam int CODE_W = 12;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  // register map (word index on the plain port)
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CH_ENABLE = 4'h1;
  localparam logic [ADDR_W-1:0] REG_INTEG_TIME = 4'h2;
  localparam logic [ADDR_W-1:0] REG_LOOP_SEL = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_RESULT_BASE = 4'h8;
  localparam logic [1:0] RANGE_X1 = 2'h0;
  localparam logic [1:0] RANGE_X2 = 2'h1;
  localparam logic [1:0] RANGE_X4 = 2'h2;
  localparam logic [1:0] RANGE_RESET = RANGE_X4;
  localparam logic [CNT_W-1:0] INTEG_RESET = 16'h0100;
  localparam logic [CODE_W-1:0] SIGN_FLIP = 12'h800;
  localparam logic [7:0] ENABLE_RESET = 8'h0f;
  localparam logic [CH_W-1:0] FIRST_SENSE_CH = 3'h4;
  localparam logic [CODE_W-1:0] PSEUDO_DC = 12'h000;
  typedef struct packed {
    logic [1:0] range;
    logic diff_lo;
    logic diff_hi;
    logic swap_lo;
    logic swap_hi;
  } conv_cfg_t;
  localparam conv_cfg_t CFG_RESET = '{range: RANGE_RESET, diff_lo: 1'b0,
    diff_hi: 1'b0, swap_lo: 1'b0, swap_hi: 1'b0};
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic write;
    logic read;
  } reg_req_t;
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_PICK, SEQ_SENSE_RESET, SEQ_INTEGRATE, SEQ_CONVERT
  } seq_state_t;
endpackage : conv_ctrl_pkg

// >>> logic/conv_ctrl.sv
`timescale 1ns/1ps
module conv_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire conv_ctrl_pkg::reg_req_t req,
  output logic [31:0] rdata,
  output logic [3:0] uncommitted_input_sel,
  output logic [3:0] integ_reset,
  output logic [3:0] integ_connect,
  output logic sample,
  input wire logic conv_done,
  input wire logic [conv_ctrl_pkg::CODE_W-1:0] raw_code,
  output logic [1:0] span,
  output logic positive_pair_input_sel,
  output logic diff_mode,
  output logic [3:0] loop_feed_valid,
  output logic [conv_ctrl_pkg::CODE_W-1:0] loop_feed_code
);
  import conv_ctrl_pkg::*;

  conv_cfg_t cfg;
  logic [7:0] ch_enable;
  logic [CNT_W-1:0] integ_time;
  logic [3:0] loop_sel;
  logic [CODE_W-1:0] result [NUM_CH];
  seq_state_t state;
  logic [CH_W-1:0] ch;
  logic [CNT_W-1:0] timer;
  logic busy;

  // next enabled channel after the given one, wrapping round
  function automatic logic [CH_W-1:0] next_ch(input logic [CH_W-1:0] cur,
      input logic [7:0] en);
    logic [CH_W-1:0] c;
    c = cur;
    for (int i = 0; i < NUM_CH; i++) begin
      c = CH_W'(c + 1'b1);
      if (en[c]) begin
        return c;
      end
    end
    return cur;
  endfunction : next_ch

  // channels 1 and 3 are absorbed by their pair partner in differential mode
  function automatic logic [7:0] live_mask(input logic [7:0] en,
      input conv_cfg_t c);
    logic [7:0] m;
    m = en;
    if (c.diff_lo) begin
      m[1] = 1'b0;
    end
    if (c.diff_hi) begin
      m[3] = 1'b0;
    end
    return m;
  endfunction : live_mask

  function automatic logic is_diff(input logic [CH_W-1:0] c,
      input conv_cfg_t g);
    return (c == 3'h0 && g.diff_lo) || (c == 3'h2 && g.diff_hi);
  endfunction : is_diff

  wire logic [7:0] live = live_mask(ch_enable, cfg);
  wire logic is_sense = ch >= FIRST_SENSE_CH;
  wire logic [1:0] sense_idx = ch[1:0];
  // a lone sense channel gets a fixed conversion time
  wire logic alone = (live & ~(8'h01 << ch)) == 8'h00;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
      ch_enable <= ENABLE_RESET;
      integ_time <= INTEG_RESET;
      loop_sel <= 4'h0;
    end else if (req.write) begin
      unique case (req.addr)
        REG_CONFIG: begin
          if (req.wdata[1:0] != 2'h3) begin
            cfg.range <= req.wdata[1:0];
          end
          cfg.diff_lo <= req.wdata[2];
          cfg.diff_hi <= req.wdata[3];
          cfg.swap_lo <= req.wdata[4];
          cfg.swap_hi <= req.wdata[5];
        end
        REG_CH_ENABLE: ch_enable <= req.wdata[7:0];
        REG_INTEG_TIME: begin
          if (req.wdata[CNT_W-1:0] != '0) begin
            integ_time <= req.wdata[CNT_W-1:0];
          end
        end
        REG_LOOP_SEL: loop_sel <= req.wdata[3:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (req.read) begin
      if (req.addr >= REG_RESULT_BASE) begin
        rdata <= {20'h00000, result[CH_W'(req.addr - REG_RESULT_BASE)]};
      end else begin
        unique case (req.addr)
          REG_CONFIG: rdata <= {26'h0, cfg.swap_hi, cfg.swap_lo, cfg.diff_hi,
            cfg.diff_lo, cfg.range};
          REG_CH_ENABLE: rdata <= {24'h0, ch_enable};
          REG_INTEG_TIME: rdata <= {16'h0, integ_time};
          REG_LOOP_SEL: rdata <= {28'h0, loop_sel};
          REG_STATUS: rdata <= {24'h0, busy, ch, 4'(state)};
          default: rdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= SEQ_IDLE;
      ch <= 3'h7;
      timer <= '0;
      busy <= 1'b0;
    end else begin
      unique case (state)
        SEQ_IDLE: begin
          busy <= 1'b0;
          if (live != 8'h00) begin
            state <= SEQ_PICK;
          end
        end
        SEQ_PICK: begin
          if (live == 8'h00) begin
            state <= SEQ_IDLE;
          end else begin
            ch <= next_ch(ch, live);
            busy <= 1'b1;
            timer <= '0;
            state <= next_ch(ch, live) >= FIRST_SENSE_CH ?
              SEQ_SENSE_RESET : SEQ_CONVERT;
          end
        end
        SEQ_SENSE_RESET: begin
          timer <= timer + 1'b1;
          if (timer == CNT_W'(RESET_HOLD_CYC - 1)) begin
            timer <= '0;
            state <= SEQ_INTEGRATE;
          end
        end
        SEQ_INTEGRATE: begin
          timer <= timer + 1'b1;
          if (timer == integ_time - 1'b1) begin
            timer <= '0;
            state <= SEQ_CONVERT;
          end
        end
        SEQ_CONVERT: begin
          timer <= timer + 1'b1;
          // lone sense channel: fixed window; others wait for conv_done
          if (is_sense && alone) begin
            if (timer == CNT_W'(SENSE_CONV_CYC - 1)) begin
              state <= SEQ_PICK;
            end
          end else if (conv_done) begin
            state <= SEQ_PICK;
          end
        end
      endcase
    end
  end

  // result capture and code formatting
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        result[i] <= '0;
      end
    end else if (state == SEQ_CONVERT && conv_done) begin
      if (is_diff(ch, cfg)) begin
        result[ch] <= raw_code ^ SIGN_FLIP;
      end else begin
        result[ch] <= raw_code;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      uncommitted_input_sel <= 4'h0;
      integ_reset <= 4'hf;
      integ_connect <= 4'h0;
      sample <= 1'b0;
      span <= RANGE_RESET;
      positive_pair_input_sel <= 1'b0;
      diff_mode <= 1'b0;
      loop_feed_valid <= 4'h0;
      loop_feed_code <= '0;
    end else begin
      span <= cfg.range;
      diff_mode <= (state == SEQ_CONVERT) && is_diff(ch, cfg);
      positive_pair_input_sel <= ch[1] ? cfg.swap_hi : cfg.swap_lo;
      uncommitted_input_sel <= (state == SEQ_CONVERT && !is_sense) ?
        4'(1 << ch[1:0]) : 4'h0;
      // idle integrators sit in reset, so a new measurement starts clean
      integ_reset <= 4'hf;
      integ_connect <= 4'h0;
      if (is_sense && state == SEQ_INTEGRATE) begin
        integ_reset[sense_idx] <= 1'b0;
        integ_connect[sense_idx] <= 1'b1;
      end else if (is_sense && state == SEQ_CONVERT) begin
        integ_reset[sense_idx] <= 1'b0;
      end
      sample <= state == SEQ_CONVERT && !conv_done;
      loop_feed_valid <= 4'h0;
      if (state == SEQ_CONVERT && conv_done && is_sense) begin
        loop_feed_valid[sense_idx] <= loop_sel[sense_idx];
        loop_feed_code <= raw_code;
      end
    end
  end
endmodule : conv_ctrl

// >>> sim/conv_ctrl_chk.sv
`timescale 1ns/1ps
module conv_ctrl_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire conv_ctrl_pkg::reg_req_t req,
  input wire logic [31:0] rdata,
  input wire logic [3:0] uncommitted_input_sel,
  input wire logic [3:0] integ_reset,
  input wire logic [3:0] integ_connect,
  input wire logic [1:0] span,
  input wire logic diff_mode
);
  import conv_ctrl_pkg::*;
  logic [CNT_W-1:0] idle_cnt;
  logic [CNT_W-1:0] conn_cnt;
  logic [CNT_W-1:0] integ_time;
  // counts every cycle with all integrators held in reset
  always_ff @(posedge clock) begin
    if (!rst_n || integ_reset != 4'hf) idle_cnt <= '0;
    else if (idle_cnt != '1) idle_cnt <= idle_cnt + 1'b1;
  end
  always_ff @(posedge clock) begin
    if (!rst_n || integ_connect == 4'h0) conn_cnt <= '0;
    else conn_cnt <= conn_cnt + 1'b1;
  end
  // zero is refused by the block, so the shadow skips it too
  always_ff @(posedge clock) begin
    if (!rst_n) integ_time <= INTEG_RESET;
    else if (req.write && req.addr == REG_INTEG_TIME && req.wdata[15:0] != 0)
      integ_time <= req.wdata[15:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rd_idle; !req.read |=> rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_span_rst; disable iff (1'b0) !rst_n |=> span == RANGE_X4;
  endproperty
  a_span_rst: assert property (p_span_rst) else $error("span reset");
  property p_span_ok; span != 2'h3; endproperty
  a_span_ok: assert property (p_span_ok) else $error("span illegal");
  property p_sel; $onehot0(uncommitted_input_sel); endproperty
  a_sel: assert property (p_sel) else $error("input select");
  property p_pair; diff_mode |-> (uncommitted_input_sel & 4'ha) == 4'h0;
  endproperty
  a_pair: assert property (p_pair) else $error("pair select");
  property p_hold; $rose(|integ_connect) |-> idle_cnt >= RESET_HOLD_CYC;
  endproperty
  a_hold: assert property (p_hold) else $error("reset hold short");
  property p_integ; $fell(|integ_connect) |-> conn_cnt == integ_time;
  endproperty
  a_integ: assert property (p_integ) else $error("integration time");
  property p_freeze;
    $fell(|integ_connect) |-> (integ_reset & $past(integ_connect)) == 4'h0;
  endproperty
  a_freeze: assert property (p_freeze) else $error("held output lost");
  property p_one; $onehot0(integ_connect); endproperty
  a_one: assert property (p_one) else $error("two sense inputs");
endmodule : conv_ctrl_chk
bind conv_ctrl conv_ctrl_chk u_chk (.clock, .rst_n, .req, .rdata,
  .uncommitted_input_sel, .integ_reset, .integ_connect, .span, .diff_mode);

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import conv_ctrl_pkg::*;
  logic clock, rst_n, conv_done, sample, pos_sel, diff_mode;
  conv_ctrl_pkg::reg_req_t req;
  logic [CODE_W-1:0] raw_code, loop_code;
  logic [31:0] rdata;
  logic [3:0] sel, integ_reset, integ_connect, loop_valid;
  logic [1:0] span;
  logic [2:0] dly;
  int err_total, n_checks, i;
  logic seen;
  conv_ctrl DUT (.clock, .rst_n, .req, .rdata, .uncommitted_input_sel(sel),
    .integ_reset, .integ_connect, .sample, .conv_done, .raw_code, .span,
    .positive_pair_input_sel(pos_sel), .diff_mode,
    .loop_feed_valid(loop_valid), .loop_feed_code(loop_code));
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  // converter core stand-in: answers a few cycles into each sample window
  always @(posedge clock) begin
    dly <= sample ? dly + 3'h1 : 3'h0;
    conv_done <= sample && dly == 3'h3;
    raw_code <= 12'h9c0 ^ {8'h0, sel};
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clock);
    req.write <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, logic [31:0] exp);
    @(posedge clock);
    req <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
    @(posedge clock);
    req.read <= 1'b0;
    #1 check("rdata", exp, rdata);
  endtask : rd
  task automatic t_reset();
    rd(REG_CONFIG, 32'h2);
    rd(REG_CH_ENABLE, 32'hf);
    rd(REG_INTEG_TIME, 32'h100);
    rd(4'h5, 32'h0);
    wr(REG_CONFIG, 32'h3);
    rd(REG_CONFIG, 32'h2);
    for (i = 0; i < 3; i++) begin
      wr(REG_CONFIG, i);
      repeat (60) @(posedge clock);
      check("span", i, span);
    end
    $display("done reset and ranges");
  endtask : t_reset
  task automatic t_single();
    wr(REG_CONFIG, 32'h2);
    repeat (100) @(posedge clock);
    for (i = 0; i < 4; i++)
      rd(4'(REG_RESULT_BASE + i), 12'h9c0 ^ (1 << i));
    $display("done single ended");
  endtask : t_single
  task automatic t_diff();
    for (int s = 0; s < 2; s++) begin
      // the two pairs get opposite swaps so each pair's choice is seen
      wr(REG_CONFIG, {s[0], !s[0], 4'he});
      repeat (100) @(posedge clock);
      for (i = 0; i < 200 && sel !== 4'h4; i++) begin
        @(posedge clock);
        #1;
      end
      check("diff hi", 1, diff_mode);
      check("positive hi", s, pos_sel);
      for (i = 0; i < 200 && sel !== 4'h1; i++) begin
        @(posedge clock);
        #1;
      end
      check("diff lo", 1, diff_mode);
      check("positive lo", !s, pos_sel);
      rd(REG_RESULT_BASE, 12'h1c1);
      rd(4'(REG_RESULT_BASE + 2), 12'h1c4);
    end
    $display("done differential");
  endtask : t_diff
  task automatic t_sense();
    wr(REG_CONFIG, 32'h2);
    wr(REG_INTEG_TIME, 32'h20);
    wr(REG_LOOP_SEL, 32'h1);
    wr(REG_CH_ENABLE, 32'h10);
    seen = 1'b0;
    for (i = 0; i < 2000 && integ_connect !== 4'h1; i++) begin
      @(posedge clock);
      #1;
    end
    for (i = 0; i < 100 && integ_connect === 4'h1; i++) begin
      @(posedge clock);
      #1;
    end
    check("integrate", 32'h20, i);
    for (i = 0; i < 1000 && integ_reset !== 4'hf; i++) begin
      @(posedge clock);
      #1;
      if (loop_valid === 4'h1 && loop_code === 12'h9c0) seen = 1'b1;
    end
    check("convert", SENSE_CONV_CYC, i);
    check("loop feed", 1, seen);
    for (i = 0; i < 2000 && integ_reset === 4'hf; i++) begin
      @(posedge clock);
      #1;
    end
    check("reset hold", 1, i >= RESET_HOLD_CYC);
    rd(4'(REG_RESULT_BASE + 4), 12'h9c0);
    $display("done sense");
  endtask : t_sense
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    give_verdict();
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    err_total = 0;
    n_checks = 0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_single();
    t_diff();
    t_sense();
    give_verdict();
  end
endmodule : testbench
